// >>> abu_break_unit.sv
// Address breakpoint unit: bus slave, address compare and break sequencing.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Address equals break address raises request
// - Vector from normal or monitor pair
// - Wait for instruction end, unless last cycle
// - Force software interrupt opcode into fetch
// - Writing active bit one forces a break
// - Return from interrupt ends the break
// - Enable bit seven gates address matches
// - Active bit set on match, written clear
// - Two address bytes, both reset zero
// - Timer halted while break active
// - Watchdog off in break with test voltage
// - Flag clears in break need clear enable
// - Works in wait; stop/wait status visible
// - Break leaves stop, sets stop/wait status
// - Clear enable zero gates flag clears in break only; a stop/wait status write of zero clears unless a break starting in stop or wait sets it
module abu_break_unit
  import abu_pkg::*;
#(
  parameter logic [7:0] SWI_OPCODE = 8'h00
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  input wire logic [15:0] CPU_ADDR,
  input wire logic CPU_ADDR_VALID,
  input wire logic CPU_LAST_CYCLE,
  input wire logic CPU_OPCODE_FETCH,
  input wire logic CPU_RTI_DONE,
  input wire logic CPU_IN_WAIT,
  input wire logic CPU_IN_STOP,
  input wire logic MONITOR_MODE,
  input wire logic RST_PIN_HIGH_VOLTAGE,
  output logic BREAKPOINT_REQUEST,
  output logic FORCE_SWI,
  output logic [7:0] SWI_OPCODE_OUT,
  output logic [15:0] VECTOR_ADDR,
  output logic BREAK_STATE,
  output logic TIMER_HALT,
  output logic WATCHDOG_DISABLE,
  output logic STOP_WAKE,
  output logic FLAG_CLEAR_ALLOW,
  output logic IRQ
);

  // ***********************************************************
  // Declarations
  // ***********************************************************
  abu_state_e state;
  abu_state_e next_state;
  logic break_enable_bit;
  logic break_active_bit;
  logic break_flag_clear_enable;
  logic stop_wait_break_status;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] next_irq_status;
  logic [31:0] next_readdata;
  logic [1:0] next_response;

  abu_wr_if addr_high_if ();
  abu_wr_if addr_low_if ();
  abu_wr_if mask_if ();

  // ***********************************************************
  // Bus decode
  // ***********************************************************

  // One wait cycle: prepare on the first edge, complete on the second.
  wire bus_req = AVS_READ | AVS_WRITE;
  wire bus_prep = bus_req & AVS_WAITREQUEST;
  wire bus_done = bus_req & ~AVS_WAITREQUEST;
  wire lane0 = AVS_BYTEENABLE[0];
  wire wr_done = bus_done & AVS_WRITE & lane0;
  wire rd_done = bus_done & AVS_READ;
  wire [7:0] wbyte = AVS_WRITEDATA[7:0];

  wire sel_high = (AVS_ADDRESS == IDX_BREAK_ADDR_HIGH);
  wire sel_low = (AVS_ADDRESS == IDX_BREAK_ADDR_LOW);
  wire sel_ctrl = (AVS_ADDRESS == IDX_BREAK_STATUS_CONTROL);
  wire sel_flag = (AVS_ADDRESS == IDX_BREAK_FLAG_CONTROL_REG);
  wire sel_stop_wait_break_status = (AVS_ADDRESS == IDX_STOP_WAIT_STATUS);
  wire sel_irqs = (AVS_ADDRESS == IDX_IRQ_STATUS);
  wire sel_mask = (AVS_ADDRESS == IDX_IRQ_MASK);
  wire sel_any = sel_high | sel_low | sel_ctrl | sel_flag | sel_stop_wait_break_status
               | sel_irqs | sel_mask;

  wire wr_ctrl = wr_done & sel_ctrl;
  wire wr_flag = wr_done & sel_flag;
  wire wr_stop_wait_break_status = wr_done & sel_stop_wait_break_status;
  wire rd_irqs = rd_done & sel_irqs;

  // Byte registers for the break address and the interrupt mask.
  // address bytes written
  assign addr_high_if.wr = wr_done & sel_high;
  assign addr_high_if.data = wbyte;
  assign addr_low_if.wr = wr_done & sel_low;
  assign addr_low_if.data = wbyte;
  assign mask_if.wr = wr_done & sel_mask;
  assign mask_if.data = wbyte;

  abu_byte_reg u_addr_high (
    .clk(CLOCK),
    .rst(RST),
    .port(addr_high_if)
  );

  abu_byte_reg u_addr_low (
    .clk(CLOCK),
    .rst(RST),
    .port(addr_low_if)
  );

  abu_byte_reg u_mask (
    .clk(CLOCK),
    .rst(RST),
    .port(mask_if)
  );

  // ***********************************************************
  // Break triggers
  // ***********************************************************

  wire [15:0] break_addr = {addr_high_if.value, addr_low_if.value};
  wire addr_match = break_enable_bit & CPU_ADDR_VALID
                  & (CPU_ADDR == break_addr);
  wire soft_break = wr_ctrl & wbyte[BIT_BREAK_ACTIVE];
  wire idle = (state == ST_IDLE);
  wire start_match = idle & addr_match;
  wire start_soft = idle & soft_break & ~addr_match;
  wire start_any = start_match | start_soft;

  // A sleeping CPU runs no instruction, so the break is injected at once.
  wire boundary = CPU_LAST_CYCLE | CPU_IN_STOP | CPU_IN_WAIT;
  wire next_in_break = (next_state == ST_INJECT) | (next_state == ST_ACTIVE);

  // ***********************************************************
  // Sequencer
  // ***********************************************************

  // Next state of the break sequence.
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (start_any)
          next_state = boundary ? ST_INJECT : ST_PENDING;
      end
      ST_PENDING:
      begin
        if (boundary)
          next_state = ST_INJECT;
      end
      ST_INJECT:
      begin
        if (CPU_OPCODE_FETCH)
          next_state = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (CPU_RTI_DONE)
          next_state = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ***********************************************************
  // Control and status bits
  // ***********************************************************

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      break_enable_bit <= 1'b0;
    else if (wr_ctrl)
      break_enable_bit <= wbyte[BIT_BREAK_ENABLE];
  end

  // match sets, write clears
  // A match in the same cycle as a write of zero keeps the bit set.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      break_active_bit <= 1'b0;
    else if (start_match)
      break_active_bit <= 1'b1;
    else if (wr_ctrl)
      break_active_bit <= wbyte[BIT_BREAK_ACTIVE];
  end

  // Flag clear enable bit, zero by default so latched flags are safe.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      break_flag_clear_enable <= 1'b0;
    else if (wr_flag)
      break_flag_clear_enable <= wbyte[BIT_FLAG_CLEAR_ENABLE];
  end

  // stop/wait status set
  // Set when a break starts while the CPU sleeps; the set beats a clear.
  // status readable in wait
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      stop_wait_break_status <= 1'b0;
    else if (start_any & (CPU_IN_STOP | CPU_IN_WAIT))
      stop_wait_break_status <= 1'b1;
    else if (wr_stop_wait_break_status & ~wbyte[BIT_STOP_WAIT_BREAK])
      stop_wait_break_status <= 1'b0;
  end

  // ***********************************************************
  // Interrupt status
  // ***********************************************************

  // Sticky events; a read clears them, but a same-cycle event is kept.
  wire [IRQ_BITS-1:0] irq_event = {start_any & CPU_IN_STOP,
                                   (state == ST_ACTIVE) & CPU_RTI_DONE,
                                   start_soft,
                                   start_match};

  always_comb
  begin
    next_irq_status = irq_status;
    if (rd_irqs)
      next_irq_status = '0;
    next_irq_status = next_irq_status | irq_event;
  end

  // Interrupt status and the line itself.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      irq_status <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      IRQ <= |(next_irq_status & mask_if.value[IRQ_BITS-1:0]);
    end
  end

  // ***********************************************************
  // Bus answer
  // ***********************************************************

  // Read data; unimplemented bits read as zero.
  always_comb
  begin
    next_readdata = '0;
    next_response = sel_any ? RESP_OKAY : RESP_SLVERR;
    if (sel_high)
      next_readdata[7:0] = addr_high_if.value;
    if (sel_low)
      next_readdata[7:0] = addr_low_if.value;
    if (sel_ctrl)
    begin
      next_readdata[BIT_BREAK_ENABLE] = break_enable_bit;
      next_readdata[BIT_BREAK_ACTIVE] = break_active_bit;
    end
    if (sel_flag)
      next_readdata[BIT_FLAG_CLEAR_ENABLE] = break_flag_clear_enable;
    if (sel_stop_wait_break_status)
      next_readdata[BIT_STOP_WAIT_BREAK] = stop_wait_break_status;
    if (sel_irqs)
      next_readdata[IRQ_BITS-1:0] = irq_status;
    if (sel_mask)
      next_readdata[7:0] = mask_if.value;
  end

  // Waitrequest drops for exactly one cycle per request.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
      AVS_RESPONSE <= RESP_OKAY;
    end
    else
    begin
      AVS_WAITREQUEST <= ~bus_prep;
      if (bus_prep)
      begin
        AVS_READDATA <= next_readdata;
        AVS_RESPONSE <= next_response;
      end
    end
  end

  // ***********************************************************
  // Outputs toward the CPU and integration logic
  // ***********************************************************

  // Side effects come from the next state to line up with the state.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      BREAKPOINT_REQUEST <= 1'b0;
      FORCE_SWI <= 1'b0;
      SWI_OPCODE_OUT <= SWI_OPCODE;
      VECTOR_ADDR <= VEC_NORMAL;
      BREAK_STATE <= 1'b0;
      TIMER_HALT <= 1'b0;
      WATCHDOG_DISABLE <= 1'b0;
      STOP_WAKE <= 1'b0;
      FLAG_CLEAR_ALLOW <= 1'b1;
    end
    else
    begin
      BREAKPOINT_REQUEST <= (next_state != ST_IDLE);
      FORCE_SWI <= (next_state == ST_INJECT);
      SWI_OPCODE_OUT <= SWI_OPCODE;
      VECTOR_ADDR <= MONITOR_MODE ? VEC_MONITOR : VEC_NORMAL;
      BREAK_STATE <= next_in_break;
      TIMER_HALT <= next_in_break;
      WATCHDOG_DISABLE <= RST_PIN_HIGH_VOLTAGE & next_in_break;
      STOP_WAKE <= CPU_IN_STOP & (next_state != ST_IDLE);
      FLAG_CLEAR_ALLOW <= break_flag_clear_enable | ~next_in_break;
    end
  end

endmodule : abu_break_unit
`default_nettype wire

// >>> abu_pkg.sv
// Package holding the register map, field layout and encodings of the breakpoint unit.
`default_nettype none
package abu_pkg;

  // ***********************************************************
  // Register indices (byte address on the bus is four times these)
  // ***********************************************************
  localparam logic [15:0] IDX_BREAK_ADDR_HIGH = 16'hFE0C;
  localparam logic [15:0] IDX_BREAK_ADDR_LOW = 16'hFE0D;
  localparam logic [15:0] IDX_BREAK_STATUS_CONTROL = 16'hFE0E;
  localparam logic [15:0] IDX_BREAK_FLAG_CONTROL_REG = 16'hFE10;
  localparam logic [15:0] IDX_STOP_WAIT_STATUS = 16'hFE11;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hFE12;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFE13;

  // ***********************************************************
  // Field positions and reset values
  // ***********************************************************
  localparam int BIT_BREAK_ENABLE = 7;
  localparam int BIT_BREAK_ACTIVE = 6;
  localparam int BIT_FLAG_CLEAR_ENABLE = 7;
  localparam int BIT_STOP_WAIT_BREAK = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Interrupt status and mask layout.
  localparam int IRQ_BITS = 4;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_SOFT = 1;
  localparam int IRQ_EXIT = 2;
  localparam int IRQ_STOP_WAKE = 3;

  // ***********************************************************
  // Vectors and bus answers
  // ***********************************************************
  localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Break sequencing states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PENDING,
    ST_INJECT,
    ST_ACTIVE
  } abu_state_e;

endpackage : abu_pkg
`default_nettype wire

// >>> abu_wr_if.sv
// Interface carrying one byte-wide register write between the unit's modules.
`timescale 1ns/10ps
`default_nettype none
interface abu_wr_if;
  logic wr;
  logic [7:0] data;
  logic [7:0] value;
  modport src (output wr, output data, input value);
  modport dst (input wr, input data, output value);
endinterface : abu_wr_if
`default_nettype wire

// >>> abu_byte_reg.sv
// Byte-wide software register with a synchronous write port.
`timescale 1ns/10ps
`default_nettype none
module abu_byte_reg
  import abu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  abu_wr_if.dst port
);

  // ***********************************************************
  // Storage
  // ***********************************************************

  // The value only changes on a bus write; reset brings it to zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      port.value <= RESET_BYTE;
    else if (port.wr)
      port.value <= port.data;
  end

endmodule : abu_byte_reg
`default_nettype wire

// >>> abu_break_unit_monitor.sv
// Checker watching the breakpoint unit's pins.
`timescale 1ns/10ps
`default_nettype none
module abu_break_monitor
  import abu_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CPU_LAST_CYCLE,
  input wire logic CPU_OPCODE_FETCH,
  input wire logic CPU_RTI_DONE,
  input wire logic CPU_IN_WAIT,
  input wire logic CPU_IN_STOP,
  input wire logic MONITOR_MODE,
  input wire logic RST_PIN_HIGH_VOLTAGE,
  input wire logic BREAKPOINT_REQUEST,
  input wire logic FORCE_SWI,
  input wire logic [15:0] VECTOR_ADDR,
  input wire logic BREAK_STATE,
  input wire logic TIMER_HALT,
  input wire logic WATCHDOG_DISABLE,
  input wire logic STOP_WAKE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // A pending break waits for an instruction boundary before injection.
  wire pend = BREAKPOINT_REQUEST && !BREAK_STATE;
  wire bound = CPU_LAST_CYCLE || CPU_IN_WAIT || CPU_IN_STOP;
  hold_pending_a: assert property (pend && !bound |=> !FORCE_SWI)
    else $error("inject before instruction end");
  inject_end_a: assert property (pend && bound |=> FORCE_SWI)
    else $error("no inject at instruction end");
  fetch_ends_a: assert property (FORCE_SWI && CPU_OPCODE_FETCH
    |=> !FORCE_SWI && BREAK_STATE) else $error("forced opcode not taken");
  rti_ends_a: assert property (BREAK_STATE && !FORCE_SWI
    && CPU_RTI_DONE |=> !BREAKPOINT_REQUEST) else $error("break not ended");
  timer_halt_a: assert property (TIMER_HALT == BREAK_STATE)
    else $error("timer halt wrong");
  wdog_off_a: assert property (!$past(RST) |-> WATCHDOG_DISABLE ==
    (BREAK_STATE && $past(RST_PIN_HIGH_VOLTAGE))) else $error("watchdog");
  stop_wake_a: assert property (!$past(RST) |-> STOP_WAKE ==
    ($past(CPU_IN_STOP) && BREAKPOINT_REQUEST)) else $error("stop wake");
  vector_sel_a: assert property (!$past(RST) |-> VECTOR_ADDR ==
    ($past(MONITOR_MODE) ? VEC_MONITOR : VEC_NORMAL)) else $error("vector");
  cover property (FORCE_SWI && CPU_OPCODE_FETCH);
  cover property (WATCHDOG_DISABLE);
  cover property (STOP_WAKE);
endmodule : abu_break_monitor

bind abu_break_unit abu_break_monitor abu_break_monitor_inst (
  .CLOCK(CLOCK), .RST(RST), .CPU_LAST_CYCLE(CPU_LAST_CYCLE),
  .CPU_OPCODE_FETCH(CPU_OPCODE_FETCH), .CPU_RTI_DONE(CPU_RTI_DONE),
  .CPU_IN_WAIT(CPU_IN_WAIT), .CPU_IN_STOP(CPU_IN_STOP),
  .MONITOR_MODE(MONITOR_MODE), .RST_PIN_HIGH_VOLTAGE(RST_PIN_HIGH_VOLTAGE),
  .BREAKPOINT_REQUEST(BREAKPOINT_REQUEST), .FORCE_SWI(FORCE_SWI),
  .VECTOR_ADDR(VECTOR_ADDR), .BREAK_STATE(BREAK_STATE),
  .TIMER_HALT(TIMER_HALT), .WATCHDOG_DISABLE(WATCHDOG_DISABLE),
  .STOP_WAKE(STOP_WAKE));
`default_nettype wire

// >>> abu_cpu_model.sv
// Behavioural CPU side: takes the forced opcode and returns from a break.
`timescale 1ns/10ps
`default_nettype none
module abu_cpu_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic force_swi,
  input wire logic break_state,
  input wire logic rti_go,
  input wire logic [3:0] fetch_delay,
  output logic opcode_fetch,
  output logic rti_done
);
  logic [3:0] wait_cnt;

  // return ends break
  // The fetch lags force_swi by fetch_delay plus one cycles, so slow cores are covered too.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_cnt <= 4'h0;
      opcode_fetch <= 1'b0;
      rti_done <= 1'b0;
    end
    else
    begin
      opcode_fetch <= force_swi && !opcode_fetch && wait_cnt == fetch_delay;
      wait_cnt <= (force_swi && wait_cnt != fetch_delay) ?
        wait_cnt + 4'h1 : 4'h0;
      rti_done <= break_state && !force_swi && rti_go && !rti_done;
    end
  end
endmodule : abu_cpu_model
`default_nettype wire

// >>> tb_abu_break_unit.sv
// Self-checking bench for the breakpoint unit.
`timescale 1ns/10ps
`default_nettype none
module tb_abu_break_unit
  import abu_pkg::*;
;
  localparam logic [7:0] OPC = 8'h83; // Arbitrary opcode value.
  logic CLOCK, RST, AVS_READ, AVS_WRITE, CPU_ADDR_VALID, CPU_LAST_CYCLE;
  logic CPU_IN_WAIT, CPU_IN_STOP, MONITOR_MODE, RST_PIN_HIGH_VOLTAGE;
  logic CPU_OPCODE_FETCH, CPU_RTI_DONE, BREAKPOINT_REQUEST, FORCE_SWI;
  logic BREAK_STATE, TIMER_HALT, WATCHDOG_DISABLE, STOP_WAKE, IRQ;
  logic FLAG_CLEAR_ALLOW, AVS_WAITREQUEST, rti_go;
  logic [15:0] AVS_ADDRESS, CPU_ADDR, VECTOR_ADDR;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [1:0] AVS_RESPONSE, rsp;
  logic [7:0] SWI_OPCODE_OUT, rd;
  logic [3:0] fetch_delay, AVS_BYTEENABLE;
  int n_mismatch = 0;
  int samples_checked = 0;

  abu_break_unit #(.SWI_OPCODE(OPC)) abu_break_unit_inst (.CLOCK(CLOCK),
    .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CPU_ADDR(CPU_ADDR), .CPU_ADDR_VALID(CPU_ADDR_VALID),
    .CPU_LAST_CYCLE(CPU_LAST_CYCLE), .CPU_OPCODE_FETCH(CPU_OPCODE_FETCH),
    .CPU_RTI_DONE(CPU_RTI_DONE), .CPU_IN_WAIT(CPU_IN_WAIT),
    .CPU_IN_STOP(CPU_IN_STOP), .MONITOR_MODE(MONITOR_MODE),
    .RST_PIN_HIGH_VOLTAGE(RST_PIN_HIGH_VOLTAGE),
    .BREAKPOINT_REQUEST(BREAKPOINT_REQUEST), .FORCE_SWI(FORCE_SWI),
    .SWI_OPCODE_OUT(SWI_OPCODE_OUT), .VECTOR_ADDR(VECTOR_ADDR),
    .BREAK_STATE(BREAK_STATE), .TIMER_HALT(TIMER_HALT),
    .WATCHDOG_DISABLE(WATCHDOG_DISABLE), .STOP_WAKE(STOP_WAKE),
    .FLAG_CLEAR_ALLOW(FLAG_CLEAR_ALLOW), .IRQ(IRQ));
  abu_cpu_model abu_cpu_model_inst (.clk(CLOCK), .rst(RST),
    .force_swi(FORCE_SWI), .break_state(BREAK_STATE), .rti_go(rti_go),
    .fetch_delay(fetch_delay), .opcode_fetch(CPU_OPCODE_FETCH),
    .rti_done(CPU_RTI_DONE));

  // A 4 ns clock.
  initial
  begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic fail(input string msg);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmpv(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("got %h expected %h", got, exp));
  endtask : cmpv

  task automatic cmpf(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("flag %b expected %b", got, exp));
  endtask : cmpf

  // One bus transfer; the request holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h000000, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge CLOCK);
      if (AVS_WAITREQUEST === 1'b0)
        break;
    end
    rd = AVS_READDATA[7:0];
    rsp = AVS_RESPONSE;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (i == 20)
    begin
      fail("no bus answer");
      finish_test();
    end
  endtask : bus

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    cmpv({8'h00, rd}, {8'h00, exp});
  endtask : rdchk

  // Waits, bounded, for a settled break state of the wanted level.
  task automatic wait_brk(input logic want);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge CLOCK);
      if (BREAK_STATE === want && FORCE_SWI === 1'b0)
        break;
    end
    if (i == 40)
    begin
      fail("break state stuck");
      finish_test();
    end
  endtask : wait_brk

  // Main sequence.
  initial
  begin
    {RST, AVS_READ, AVS_WRITE, CPU_ADDR_VALID, CPU_LAST_CYCLE} = 5'h10;
    {CPU_IN_WAIT, CPU_IN_STOP, MONITOR_MODE, RST_PIN_HIGH_VOLTAGE} = 4'h0;
    {AVS_ADDRESS, CPU_ADDR, AVS_WRITEDATA} = 64'h0;
    AVS_BYTEENABLE = 4'hF;
    rti_go = 1'b0;
    fetch_delay = 4'h3;
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    rdchk(IDX_BREAK_ADDR_HIGH, 8'h00);
    rdchk(IDX_BREAK_ADDR_LOW, 8'h00);
    rdchk(IDX_BREAK_STATUS_CONTROL, 8'h00);
    cmpv({14'h0000, rsp}, {14'h0000, RESP_OKAY});
    rdchk(16'hFE0F, 8'h00);
    cmpv({14'h0000, rsp}, {14'h0000, RESP_SLVERR});
    $display("test reset done");
    bus(1'b1, IDX_BREAK_ADDR_HIGH, 8'h12);
    bus(1'b1, IDX_BREAK_ADDR_LOW, 8'h34);
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, IDX_BREAK_ADDR_HIGH, 8'hFF);
    AVS_BYTEENABLE <= 4'hF;
    rdchk(IDX_BREAK_ADDR_HIGH, 8'h12);
    rdchk(IDX_BREAK_ADDR_LOW, 8'h34);
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h80);
    CPU_ADDR <= 16'h1234;
    CPU_ADDR_VALID <= 1'b1;
    repeat (4) @(posedge CLOCK);
    cmpf(BREAKPOINT_REQUEST, 1'b1);
    cmpf(FORCE_SWI, 1'b0);
    CPU_ADDR_VALID <= 1'b0;
    CPU_LAST_CYCLE <= 1'b1;
    @(posedge CLOCK);
    CPU_LAST_CYCLE <= 1'b0;
    wait_brk(1'b1);
    cmpf(TIMER_HALT, 1'b1);
    cmpf(WATCHDOG_DISABLE, 1'b0);
    cmpf(FLAG_CLEAR_ALLOW, 1'b0);
    cmpv(VECTOR_ADDR, VEC_NORMAL);
    cmpv({8'h00, SWI_OPCODE_OUT}, {8'h00, OPC});
    rdchk(IDX_BREAK_STATUS_CONTROL, 8'hC0);
    rdchk(IDX_IRQ_STATUS, 8'h01);
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h80);
    rdchk(IDX_BREAK_STATUS_CONTROL, 8'h80);
    rti_go <= 1'b1;
    wait_brk(1'b0);
    rti_go <= 1'b0;
    cmpf(BREAKPOINT_REQUEST, 1'b0);
    cmpf(IRQ, 1'b0);
    bus(1'b1, IDX_IRQ_MASK, 8'h04);
    repeat (2) @(posedge CLOCK);
    cmpf(IRQ, 1'b1);
    rdchk(IDX_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge CLOCK);
    cmpf(IRQ, 1'b0);
    $display("test match break done");
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h00);
    CPU_ADDR_VALID <= 1'b1;
    repeat (4) @(posedge CLOCK);
    cmpf(BREAKPOINT_REQUEST, 1'b0);
    CPU_ADDR_VALID <= 1'b0;
    $display("test disabled match done");
    MONITOR_MODE <= 1'b1;
    RST_PIN_HIGH_VOLTAGE <= 1'b1;
    CPU_IN_STOP <= 1'b1;
    fetch_delay <= 4'h0;
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h40);
    wait_brk(1'b1);
    cmpv(VECTOR_ADDR, VEC_MONITOR);
    cmpf(WATCHDOG_DISABLE, 1'b1);
    cmpf(STOP_WAKE, 1'b1);
    cmpf(FLAG_CLEAR_ALLOW, 1'b0);
    rdchk(IDX_STOP_WAIT_STATUS, 8'h02);
    bus(1'b1, IDX_STOP_WAIT_STATUS, 8'h00);
    rdchk(IDX_STOP_WAIT_STATUS, 8'h00);
    bus(1'b1, IDX_BREAK_FLAG_CONTROL_REG, 8'h80);
    repeat (2) @(posedge CLOCK);
    cmpf(FLAG_CLEAR_ALLOW, 1'b1);
    CPU_IN_STOP <= 1'b0;
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h00);
    rti_go <= 1'b1;
    wait_brk(1'b0);
    rti_go <= 1'b0;
    $display("test software break done");
    CPU_IN_WAIT <= 1'b1;
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h80);
    CPU_ADDR_VALID <= 1'b1;
    wait_brk(1'b1);
    CPU_ADDR_VALID <= 1'b0;
    cmpf(STOP_WAKE, 1'b0);
    rdchk(IDX_STOP_WAIT_STATUS, 8'h02);
    bus(1'b1, IDX_BREAK_STATUS_CONTROL, 8'h00);
    rti_go <= 1'b1;
    wait_brk(1'b0);
    rti_go <= 1'b0;
    CPU_IN_WAIT <= 1'b0;
    cmpf(IRQ, 1'b1);
    rdchk(IDX_IRQ_STATUS, 8'h0F);
    $display("test wait break done");
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    cmpf(BREAKPOINT_REQUEST, 1'b0);
    rdchk(IDX_BREAK_ADDR_HIGH, 8'h00);
    rdchk(IDX_IRQ_MASK, 8'h00);
    cmpf(IRQ, 1'b0);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : tb_abu_break_unit
`default_nettype wire
